// [design/dso_top.sv]
// drive vendor status word and maker command objects
// Behaviour
// [R1] origin flag set only when homed and position inside origin range.
// [R2] csp: distribution complete when pre or post filter increment zero in cycle.
// [R3] homing: also needs internal generator finished up to target position.
// [R4] zero speed flag while |actual velocity| below zero speed threshold.
// [R5] force limit flag follows force limiting, forced 0 while servo off.
// [R6] flag setting 0 judges including force command, 1 excluding it.
// [R7] speed limit flag in force control while speed is being clamped.
// [R8] selection 0 clamps to limit value; 1 to smaller of it and max velocity.
// [R9] speed agreement forced 0 when target ignored 0 during prohibit deceleration.
// [R10] positive soft limit flag when position above maximum limit.
// [R11] negative soft limit flag when position below minimum limit.
// [R12] both soft limit flags 0 when function disabled or not homed.
// [R13] speed agreement when |command speed minus actual speed| below range.
// [R14] position control only: proximity when |position error| below second range.
// [R15] command ready 0 while any write, commit, reset, clear, backup runs.
// [R16] command ready 0 from servo on/off acceptance until state reached.
// [R17] commit key written over mailbox applies changes of class C objects.
// [R18] commit while servo on forces the servo off.
// [R19] after commit the drive faults with error 27.7.
// [R20] commit aborts on complete access, wrong key or undervoltage error.
// [R21] reset key written over mailbox clears the fault status.
// [R22] fault reset aborts only on complete access or wrong key; code also aborts while a commit or reset still runs.
// [R23] bits 10 to 15 reserved; unsupported bits undefined.
// [R24] sub error code: f0..f9 sub number high byte, main number low byte.
// [R25] flags evaluated once per communications cycle, presented coherently.
`timescale 1ns/1ps
module dso_top #(
  parameter int W = 32,
  parameter int COMM_CYCLES = dso_pkg::COMM_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  // mailbox object access
  input wire logic sdo_req,
  input wire logic sdo_we,
  input wire logic sdo_complete_access,
  input wire logic [15:0] sdo_index,
  input wire logic [31:0] sdo_wdata,
  output logic sdo_ack,
  output logic sdo_abort,
  output logic [31:0] sdo_abort_code,
  output logic [31:0] sdo_rdata,
  // process data status word
  output logic [15:0] pdo_status,
  output logic comm_tick,
  // drive state
  input wire logic [7:0] mode_of_op,
  input wire logic homing_done,
  input wire logic signed [W-1:0] pos_actual,
  input wire logic [W-1:0] origin_range,
  input wire logic signed [W-1:0] cmd_incr_pre,
  input wire logic signed [W-1:0] cmd_incr_post,
  input wire logic gen_dist_done,
  input wire logic signed [W-1:0] vel_actual,
  input wire logic [W-1:0] zero_speed_thr,
  input wire logic servo_on,
  input wire logic flim_incl_cmd,
  input wire logic flim_excl_cmd,
  input wire logic flim_sel,
  input wire logic signed [W-1:0] speed_cmd,
  input wire logic [W-1:0] speed_limit_value,
  input wire logic [W-1:0] max_profile_vel,
  input wire logic speed_limit_sel,
  output logic signed [W-1:0] speed_clamped,
  input wire logic target_ignored,
  input wire logic prohibit_decel,
  input wire logic soft_limit_en,
  input wire logic signed [W-1:0] pos_limit_max,
  input wire logic signed [W-1:0] pos_limit_min,
  input wire logic signed [W-1:0] speed_cmd_pre_acc,
  input wire logic [W-1:0] agree_range,
  input wire logic signed [W-1:0] pos_err_cmd,
  input wire logic [W-1:0] prox_range,
  // other background work and servo transitions
  input wire logic hist_clear_busy,
  input wire logic backup_busy,
  input wire logic save_busy,
  input wire logic restore_busy,
  input wire logic servo_cmd_accept,
  input wire logic servo_state_reached,
  input wire logic undervolt_err,
  // error reporting
  input wire logic err_set,
  input wire logic [7:0] err_main,
  input wire logic [3:0] err_sub,
  output logic fault,
  output logic servo_force_off,
  output logic config_apply,
  output logic [15:0] coord_mode,
  output logic [31:0] coord_pos
);
  // ==========
  // communications cycle divider
  logic [$clog2(COMM_CYCLES)-1:0] div_q;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      div_q <= '0;
    end else if (div_q == ($clog2(COMM_CYCLES))'(COMM_CYCLES - 1)) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + 1'b1;
    end
  end
  assign comm_tick = div_q == ($clog2(COMM_CYCLES))'(COMM_CYCLES - 1);

  // ==========
  // mailbox decode
  logic wr_commit;
  logic wr_reset;
  logic commit_ok;
  logic reset_ok;
  logic [31:0] code_d;
  logic [31:0] rdata_d;
  logic abort_d;
  logic [31:0] commit_key_q;
  logic [31:0] reset_key_q;
  logic [15:0] sub_err_q;
  logic [15:0] coord_mode_q;
  logic [31:0] coord_pos_q;
  dso_pkg::op_type op_q;

  assign wr_commit = sdo_req && sdo_we && sdo_index == dso_pkg::IDX_COMMIT;
  assign wr_reset = sdo_req && sdo_we && sdo_index == dso_pkg::IDX_FAULT_RST;
  assign commit_ok = wr_commit && !sdo_complete_access && sdo_wdata == dso_pkg::KEY_COMMIT
    && !undervolt_err && op_q == dso_pkg::OP_IDLE; // [R20] [R17]
  assign reset_ok = wr_reset && !sdo_complete_access && sdo_wdata == dso_pkg::KEY_FAULT_RST
    && op_q == dso_pkg::OP_IDLE; // [R22] [R21]

  always_comb begin
    abort_d = 1'b0;
    code_d = '0;
    rdata_d = '0;
    case (sdo_index)
      dso_pkg::IDX_VSTATUS: begin
        rdata_d = {16'h0000, pdo_status};
        if (sdo_we) begin
          abort_d = 1'b1;
          code_d = dso_pkg::ABORT_RO;
        end
      end
      dso_pkg::IDX_SUB_ERR: begin
        rdata_d = {16'h0000, sub_err_q};
        if (sdo_we) begin
          abort_d = 1'b1;
          code_d = dso_pkg::ABORT_RO;
        end
      end
      dso_pkg::IDX_COMMIT, dso_pkg::IDX_FAULT_RST: begin
        rdata_d = sdo_index == dso_pkg::IDX_COMMIT ? commit_key_q : reset_key_q;
        if (sdo_we && sdo_complete_access) begin
          abort_d = 1'b1;
          code_d = dso_pkg::ABORT_CA; // [R20] [R22]
        end else if (sdo_we && sdo_wdata != (sdo_index == dso_pkg::IDX_COMMIT ?
          dso_pkg::KEY_COMMIT : dso_pkg::KEY_FAULT_RST)) begin
          abort_d = 1'b1;
          code_d = dso_pkg::ABORT_VALUE; // [R20] [R22]
        end else if (sdo_we && sdo_index == dso_pkg::IDX_COMMIT && undervolt_err) begin
          abort_d = 1'b1;
          code_d = dso_pkg::ABORT_STATE; // [R20]
        end else if (sdo_we && op_q != dso_pkg::OP_IDLE) begin
          // only one commit or fault reset at a time
          abort_d = 1'b1;
          code_d = dso_pkg::ABORT_STATE;
        end
      end
      dso_pkg::IDX_COORD_MODE: begin
        rdata_d = {16'h0000, coord_mode_q};
      end
      dso_pkg::IDX_COORD_POS: begin
        rdata_d = coord_pos_q;
      end
      default: begin
        abort_d = 1'b1;
        code_d = dso_pkg::ABORT_NO_OBJ;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sdo_ack <= 1'b0;
      sdo_abort <= 1'b0;
      sdo_abort_code <= '0;
      sdo_rdata <= '0;
    end else begin
      sdo_ack <= sdo_req;
      sdo_abort <= sdo_req && abort_d;
      sdo_abort_code <= sdo_req ? code_d : '0;
      sdo_rdata <= sdo_req ? rdata_d : '0;
    end
  end

  // ==========
  // stored objects
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      commit_key_q <= dso_pkg::RST_COMMIT;
      reset_key_q <= dso_pkg::RST_FAULT_RST;
      coord_mode_q <= dso_pkg::RST_COORD_MODE;
      coord_pos_q <= dso_pkg::RST_COORD_POS;
    end else if (sdo_req && sdo_we) begin
      if (commit_ok) begin
        commit_key_q <= sdo_wdata;
      end
      if (reset_ok) begin
        reset_key_q <= sdo_wdata;
      end
      if (sdo_index == dso_pkg::IDX_COORD_MODE) begin
        coord_mode_q <= sdo_wdata[15:0];
      end
      if (sdo_index == dso_pkg::IDX_COORD_POS) begin
        coord_pos_q <= sdo_wdata;
      end
    end
  end
  assign coord_mode = coord_mode_q;
  assign coord_pos = coord_pos_q;

  // ==========
  // commit and fault reset operations
  logic commit_busy;
  logic commit_done;
  logic reset_busy;
  logic reset_done;

  dso_op_timer #(.N(dso_pkg::COMMIT_CYCLES)) u_commit_tmr (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .start(commit_ok),
    .busy(commit_busy),
    .done(commit_done)
  );
  dso_op_timer #(.N(dso_pkg::RESET_CYCLES)) u_reset_tmr (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .start(reset_ok),
    .busy(reset_busy),
    .done(reset_done)
  );

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      op_q <= dso_pkg::OP_IDLE;
    end else begin
      case (op_q)
        dso_pkg::OP_IDLE: begin
          if (commit_ok) begin
            op_q <= dso_pkg::OP_COMMIT;
          end else if (reset_ok) begin
            op_q <= dso_pkg::OP_RESET;
          end
        end
        dso_pkg::OP_COMMIT: begin
          if (commit_done) begin
            op_q <= dso_pkg::OP_IDLE;
          end
        end
        dso_pkg::OP_RESET: begin
          if (reset_done) begin
            op_q <= dso_pkg::OP_IDLE;
          end
        end
        default: begin
          op_q <= dso_pkg::OP_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      servo_force_off <= 1'b0;
      config_apply <= 1'b0;
    end else begin
      servo_force_off <= commit_ok && servo_on; // [R18]
      config_apply <= commit_done; // [R17]
    end
  end

  // fault and sub error code; a new error wins over a reset finishing
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      fault <= 1'b0;
      sub_err_q <= dso_pkg::RST_SUB_ERR;
    end else if (commit_done) begin
      fault <= 1'b1; // [R19]
      sub_err_q <= {dso_pkg::ERR_SUB_TAG, dso_pkg::ERR_COMMIT_SUB,
        dso_pkg::ERR_COMMIT_MAIN}; // [R24]
    end else if (err_set) begin
      fault <= 1'b1;
      sub_err_q <= {dso_pkg::ERR_SUB_TAG, err_sub, err_main}; // [R24]
    end else if (reset_done) begin
      fault <= 1'b0; // [R21]
      sub_err_q <= dso_pkg::RST_SUB_ERR;
    end
  end

  // ==========
  // command ready
  logic servo_trans_q;
  logic cmd_busy;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      servo_trans_q <= 1'b0;
    end else if (servo_cmd_accept) begin
      servo_trans_q <= 1'b1; // [R16]
    end else if (servo_state_reached) begin
      servo_trans_q <= 1'b0; // [R16]
    end
  end
  assign cmd_busy = (sdo_req && sdo_we) || sdo_ack || commit_busy || reset_busy
    || hist_clear_busy || backup_busy || save_busy || restore_busy
    || servo_trans_q || servo_cmd_accept; // [R15] [R16]

  // ==========
  // distribution tracking across one communications cycle
  logic pre_moved_q;
  logic post_moved_q;
  logic pre_moved;
  logic post_moved;
  assign pre_moved = pre_moved_q || cmd_incr_pre != '0;
  assign post_moved = post_moved_q || cmd_incr_post != '0;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pre_moved_q <= 1'b0;
      post_moved_q <= 1'b0;
    end else if (comm_tick) begin
      pre_moved_q <= 1'b0;
      post_moved_q <= 1'b0;
    end else begin
      pre_moved_q <= pre_moved;
      post_moved_q <= post_moved;
    end
  end

  // ==========
  // magnitude comparisons
  logic in_origin;
  logic zero_speed;
  logic speeds_agree;
  logic proximity_flag_pos;
  dso_mag_below #(.W(W)) u_origin (
    .a(pos_actual),
    .b('0),
    .thr(origin_range),
    .below(in_origin)
  );
  dso_mag_below #(.W(W)) u_zero_speed_signal (
    .a(vel_actual),
    .b('0),
    .thr(zero_speed_thr),
    .below(zero_speed)
  );
  dso_mag_below #(.W(W)) u_agree (
    .a(speed_cmd_pre_acc),
    .b(vel_actual),
    .thr(agree_range),
    .below(speeds_agree)
  );
  dso_mag_below #(.W(W)) u_prox (
    .a(pos_err_cmd),
    .b('0),
    .thr(prox_range),
    .below(proximity_flag_pos)
  );

  // ==========
  // speed clamp in force control
  logic [W-1:0] limit_eff;
  logic [W-1:0] speed_mag;
  logic clamping;
  assign limit_eff = (speed_limit_sel && max_profile_vel < speed_limit_value) ?
    max_profile_vel : speed_limit_value; // [R8]
  assign speed_mag = speed_cmd[W-1] ? W'(-speed_cmd) : W'(speed_cmd);
  assign clamping = mode_of_op == dso_pkg::MODE_CST && speed_mag > limit_eff; // [R7]
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      speed_clamped <= '0;
    end else if (!clamping) begin
      speed_clamped <= speed_cmd;
    end else begin
      speed_clamped <= speed_cmd[W-1] ? W'(-limit_eff) : limit_eff; // [R8]
    end
  end

  // ==========
  // status word, latched once per communications cycle
  logic pos_ctrl;
  logic soft_ok;
  logic [15:0] status_d;
  logic [15:0] status_q;
  assign pos_ctrl = mode_of_op == dso_pkg::MODE_CSP || mode_of_op == dso_pkg::MODE_HM;
  assign soft_ok = soft_limit_en && homing_done; // [R12]

  always_comb begin
    status_d = '0; // [R23]
    status_d[dso_pkg::BIT_ORIGIN] = homing_done && in_origin; // [R1]
    if (mode_of_op == dso_pkg::MODE_CSP) begin
      status_d[dso_pkg::BIT_DEN] = !pre_moved || !post_moved; // [R2]
    end else if (mode_of_op == dso_pkg::MODE_HM) begin
      status_d[dso_pkg::BIT_DEN] = (!pre_moved || !post_moved) && gen_dist_done; // [R3]
    end
    status_d[dso_pkg::BIT_ZERO_SPEED_SIGNAL] = zero_speed; // [R4]
    status_d[dso_pkg::BIT_FLIM] = servo_on && (flim_sel ? flim_excl_cmd : flim_incl_cmd); // [R5] [R6]
    status_d[dso_pkg::BIT_VLIM] = clamping; // [R7]
    status_d[dso_pkg::BIT_PSOFT] = soft_ok && pos_actual > pos_limit_max; // [R10] [R12]
    status_d[dso_pkg::BIT_NSOFT] = soft_ok && pos_actual < pos_limit_min; // [R11] [R12]
    status_d[dso_pkg::BIT_VAGREE] = speeds_agree && !(prohibit_decel && !target_ignored); // [R13] [R9]
    status_d[dso_pkg::BIT_PROX] = pos_ctrl && proximity_flag_pos; // [R14]
    status_d[dso_pkg::BIT_COMMAND_READY_FLAG] = !cmd_busy; // [R15]
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      status_q <= '0;
    end else if (comm_tick) begin
      status_q <= status_d; // [R25]
    end
  end
  assign pdo_status = status_q;
endmodule : dso_top

// [design/dso_pkg.sv]
// constants for the drive status word and command objects
package dso_pkg;
  // ==========
  // object indices
  localparam logic [15:0] IDX_VSTATUS = 16'h4000;
  localparam logic [15:0] IDX_SUB_ERR = 16'h4001;
  localparam logic [15:0] IDX_COMMIT = 16'h4100;
  localparam logic [15:0] IDX_COORD_MODE = 16'h4103;
  localparam logic [15:0] IDX_COORD_POS = 16'h4104;
  localparam logic [15:0] IDX_FAULT_RST = 16'h4107;
  // ==========
  // reset values and keys
  localparam logic [15:0] RST_SUB_ERR = 16'h0000;
  localparam logic [31:0] RST_COMMIT = 32'h00000000;
  localparam logic [15:0] RST_COORD_MODE = 16'h0083;
  localparam logic [31:0] RST_COORD_POS = 32'h00000000;
  localparam logic [31:0] RST_FAULT_RST = 32'h00000000;
  localparam logic [31:0] KEY_COMMIT = 32'h666e6f63;
  localparam logic [31:0] KEY_FAULT_RST = 32'h74737274;
  // ==========
  // status word bit positions, bits 10 to 15 reserved
  localparam int BIT_ORIGIN = 0;
  localparam int BIT_DEN = 1;
  localparam int BIT_ZERO_SPEED_SIGNAL = 2;
  localparam int BIT_FLIM = 3;
  localparam int BIT_VLIM = 4;
  localparam int BIT_PSOFT = 5;
  localparam int BIT_NSOFT = 6;
  localparam int BIT_VAGREE = 7;
  localparam int BIT_PROX = 8;
  localparam int BIT_COMMAND_READY_FLAG = 9;
  // ==========
  // error codes, sub number in upper byte as f0..f9
  localparam logic [7:0] ERR_COMMIT_MAIN = 8'h27;
  localparam logic [3:0] ERR_COMMIT_SUB = 4'h7;
  localparam logic [3:0] ERR_SUB_TAG = 4'hf;
  // ==========
  // abort codes of the mailbox protocol
  localparam logic [31:0] ABORT_NO_OBJ = 32'h06020000;
  localparam logic [31:0] ABORT_RO = 32'h06010002;
  localparam logic [31:0] ABORT_CA = 32'h06010000;
  localparam logic [31:0] ABORT_VALUE = 32'h06090030;
  localparam logic [31:0] ABORT_STATE = 32'h08000022;
  // ==========
  // modes of operation
  localparam logic [7:0] MODE_HM = 8'h06;
  localparam logic [7:0] MODE_CSP = 8'h08;
  localparam logic [7:0] MODE_CSV = 8'h09;
  localparam logic [7:0] MODE_CST = 8'h0a;
  // ==========
  // timing
  localparam int CLK_MHZ = 125;
  localparam int COMM_CYCLE_US = 1000;
  localparam int COMM_CYCLES = COMM_CYCLE_US * CLK_MHZ;
  localparam int COMMIT_TIME_US = 20;
  localparam int COMMIT_CYCLES = COMMIT_TIME_US * CLK_MHZ;
  localparam int RESET_TIME_US = 4;
  localparam int RESET_CYCLES = RESET_TIME_US * CLK_MHZ;
  // ==========
  // background operation states
  typedef enum logic [1:0] {
    OP_IDLE = 2'b00,
    OP_COMMIT = 2'b01,
    OP_RESET = 2'b11
  } op_type;
endpackage : dso_pkg

// [design/dso_mag_below.sv]
// magnitude compare: |a - b| below a threshold
`timescale 1ns/1ps
module dso_mag_below #(
  parameter int W = 32
) (
  input wire logic signed [W-1:0] a,
  input wire logic signed [W-1:0] b,
  input wire logic [W-1:0] thr,
  output logic below
);
  logic signed [W:0] diff;
  logic [W:0] mag;
  // one extra bit so extreme operands cannot wrap
  assign diff = W'(1) == 1 ? ({a[W-1], a} - {b[W-1], b}) : '0;
  assign mag = diff[W] ? (W+1)'(-diff) : diff;
  assign below = mag < {1'b0, thr};
endmodule : dso_mag_below

// [design/dso_op_timer.sv]
// busy timer for a background operation
`timescale 1ns/1ps
module dso_op_timer #(
  parameter int N = 16
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic start,
  output logic busy,
  output logic done
);
  logic [$clog2(N+1)-1:0] cnt_q;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
    end else if (start && cnt_q == '0) begin
      cnt_q <= ($clog2(N+1))'(N);
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end
  assign busy = cnt_q != '0;
  assign done = cnt_q == ($clog2(N+1))'(1);
endmodule : dso_op_timer

// [sim/dso_properties.sv]
// assertion checker for the drive status word and command objects
`timescale 1ns/1ps
module dso_properties (
  input logic clk_sys,
  input logic rst_n,
  input logic sdo_req,
  input logic sdo_we,
  input logic sdo_complete_access,
  input logic [15:0] sdo_index,
  input logic [31:0] sdo_wdata,
  input logic sdo_ack,
  input logic sdo_abort,
  input logic [31:0] sdo_abort_code,
  input logic [15:0] pdo_status,
  input logic comm_tick,
  input logic servo_on,
  input logic soft_limit_en,
  input logic backup_busy,
  input logic fault,
  input logic servo_force_off,
  input logic config_apply
);
  // ==========
  // helpers
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  logic wr_commit;
  logic wr_reset;
  assign wr_commit = sdo_req && sdo_we && sdo_index == dso_pkg::IDX_COMMIT;
  assign wr_reset = sdo_req && sdo_we && sdo_index == dso_pkg::IDX_FAULT_RST;
  // ==========
  // mailbox
  a_ack_after_req: assert property (sdo_req |=> sdo_ack) else $error("no answer");
  a_ack_has_cause: assert property (sdo_ack |-> $past(sdo_req)) else $error("stray ack");
  a_commit_ca_abort: assert property (wr_commit && sdo_complete_access |=>
    sdo_abort && sdo_abort_code == dso_pkg::ABORT_CA) else $error("commit ca taken");
  a_commit_bad_key: assert property (wr_commit && sdo_wdata != dso_pkg::KEY_COMMIT |=>
    sdo_abort) else $error("commit bad key taken");
  a_reset_ca_abort: assert property (wr_reset && sdo_complete_access |=>
    sdo_abort && sdo_abort_code == dso_pkg::ABORT_CA) else $error("reset ca taken");
  a_reset_bad_key: assert property (wr_reset && sdo_wdata != dso_pkg::KEY_FAULT_RST |=>
    sdo_abort) else $error("reset bad key taken");
  a_commit_servo_off: assert property (sdo_ack && !sdo_abort && $past(wr_commit)
    && $past(servo_on) |-> servo_force_off) else $error("servo kept on");
  a_commit_then_fault: assert property (config_apply |-> ##[0:1] fault)
    else $error("no fault");
  // ==========
  // status word
  a_reserved_zero: assert property (pdo_status[15:10] == 6'h00) else $error("reserved set");
  a_status_on_tick: assert property (!$past(comm_tick) |-> $stable(pdo_status))
    else $error("status off tick");
  a_flim_servo_off: assert property ($past(comm_tick) && !$past(servo_on)
    |-> !pdo_status[3]) else $error("force limit servo off");
  a_soft_disabled: assert property ($past(comm_tick) && !$past(soft_limit_en)
    |-> pdo_status[6:5] == 2'b00) else $error("soft limit disabled");
  a_ready_busy: assert property ($past(comm_tick) && $past(backup_busy)
    |-> !pdo_status[9]) else $error("ready while busy");
  c_commit_taken: cover property (sdo_ack && !sdo_abort && $past(wr_commit));
  c_reset_taken: cover property (sdo_ack && !sdo_abort && $past(wr_reset));
  c_commit_done: cover property (config_apply);
endmodule : dso_properties

bind dso_top dso_properties dso_properties_inst (.*);

// [sim/dso_master.sv]
// mailbox master model issuing single object accesses
`timescale 1ns/1ps
module dso_master (
  input logic clk_sys,
  input logic sdo_ack,
  input logic [31:0] sdo_abort_code,
  input logic [31:0] sdo_rdata,
  output logic sdo_req,
  output logic sdo_we,
  output logic sdo_complete_access,
  output logic [15:0] sdo_index,
  output logic [31:0] sdo_wdata
);
  logic timed_out = 1'b0;
  initial begin
    {sdo_req, sdo_we, sdo_complete_access, sdo_index, sdo_wdata} = '0;
  end
  task automatic access(input logic we, input logic ca, input logic [15:0] idx,
                        input logic [31:0] wd, output logic [31:0] code,
                        output logic [31:0] rd);
    int n = 0;
    @(posedge clk_sys);
    #1;
    {sdo_req, sdo_we, sdo_complete_access, sdo_index, sdo_wdata} = {1'b1, we, ca, idx, wd};
    @(posedge clk_sys);
    #1;
    // idle index and data inverted so stale values show
    {sdo_req, sdo_index, sdo_wdata} = {1'b0, ~idx, ~wd};
    while (sdo_ack !== 1'b1 && n < 4) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    if (sdo_ack !== 1'b1) timed_out = 1'b1;
    code = sdo_abort_code;
    rd = sdo_rdata;
  endtask : access
endmodule : dso_master

// [sim/tb_top.sv]
// self-checking bench for the drive status word and command objects
`timescale 1ns/1ps
module tb_top;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic sdo_req, sdo_we, sdo_complete_access, sdo_ack, sdo_abort, comm_tick;
  logic fault, servo_force_off, config_apply;
  logic [15:0] sdo_index, pdo_status, coord_mode;
  logic [31:0] sdo_wdata, sdo_abort_code, sdo_rdata, coord_pos, code, rd;
  logic signed [31:0] speed_clamped;
  logic [7:0] mode_of_op = dso_pkg::MODE_CSP, err_main = 8'h00;
  logic [3:0] err_sub = 4'h0;
  logic homing_done = 1'b1, servo_on = 1'b1, flim_incl_cmd = 1'b1, soft_limit_en = 1'b1;
  logic gen_dist_done = 1'b0, flim_excl_cmd = 1'b0, flim_sel = 1'b0, speed_limit_sel = 1'b0;
  logic target_ignored = 1'b0, prohibit_decel = 1'b0, hist_clear_busy = 1'b0, save_busy = 1'b0;
  logic restore_busy = 1'b0, backup_busy = 1'b0, servo_cmd_accept = 1'b0, err_set = 1'b0;
  logic servo_state_reached = 1'b0, undervolt_err = 1'b0;
  logic signed [31:0] pos_actual = 32'sh5, cmd_incr_pre = 32'sh7, cmd_incr_post = 32'sh0;
  logic signed [31:0] vel_actual = 32'sh0, speed_cmd = 32'sh0, pos_limit_max = 32'sh3;
  logic signed [31:0] pos_limit_min = -32'sh64, speed_cmd_pre_acc = 32'sh0, pos_err_cmd = 32'sh0;
  logic [31:0] origin_range = 32'ha, zero_speed_thr = 32'h3, speed_limit_value = 32'h0;
  logic [31:0] max_profile_vel = 32'h0, agree_range = 32'h2, prox_range = 32'h1;
  int num_errors = 0;
  int num_checks = 0;
  // short cycle keeps the run small
  dso_top #(.COMM_CYCLES(16)) dso_top_inst (.*);
  dso_master dso_master_inst (.*);
  always #4 clk_sys = ~clk_sys;
  // ==========
  // helpers
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic step();
    @(posedge clk_sys);
    #1;
  endtask : step
  task automatic acc(input logic we, input logic ca, input logic [15:0] idx,
                     input logic [31:0] wd, input logic [31:0] exp_code,
                     input logic [31:0] exp_rd);
    dso_master_inst.access(we, ca, idx, wd, code, rd);
    if (dso_master_inst.timed_out) begin
      num_errors++;
      $display("mismatch at %0t: no answer", $time);
      report_and_stop();
    end
    chk(code, exp_code);
    chk(rd, exp_rd);
  endtask : acc
  task automatic wr(input logic ca, input logic [15:0] idx, input logic [31:0] wd,
                    input logic [31:0] exp_code);
    acc(1'b1, ca, idx, wd, exp_code, 32'h0);
  endtask : wr
  task automatic rd_is(input logic [15:0] idx, input logic [31:0] exp_rd);
    acc(1'b0, 1'b0, idx, 32'h0, 32'h0, exp_rd);
  endtask : rd_is
  task automatic wait_high(input bit apply, input int lim);
    for (int n = 0; n < lim; n++) begin
      step();
      if ((apply ? config_apply : comm_tick) === 1'b1) return;
    end
    num_errors++;
    $display("mismatch at %0t: wait ran out", $time);
    report_and_stop();
  endtask : wait_high
  // one full cycle, then its latch
  task automatic status_is(input logic [15:0] exp);
    wait_high(1'b0, 40);
    wait_high(1'b0, 40);
    step();
    chk({16'h0, pdo_status}, {16'h0, exp});
  endtask : status_is
  // ==========
  // main sequence
  initial begin
    repeat (10) @(posedge clk_sys);
    #1;
    rst_n = 1'b1;
    rd_is(dso_pkg::IDX_COORD_MODE, 32'h83);
    chk({16'h0, coord_mode}, 32'h83);
    rd_is(dso_pkg::IDX_SUB_ERR, 32'h0);
    rd_is(dso_pkg::IDX_COMMIT, 32'h0);
    rd_is(dso_pkg::IDX_FAULT_RST, 32'h0);
    acc(1'b0, 1'b0, 16'h4200, 32'h0, dso_pkg::ABORT_NO_OBJ, 32'h0);
    wr(1'b0, dso_pkg::IDX_SUB_ERR, 32'h1, dso_pkg::ABORT_RO);
    wr(1'b0, dso_pkg::IDX_COORD_POS, 32'h12345678, 32'h0);
    rd_is(dso_pkg::IDX_COORD_POS, 32'h12345678);
    chk(coord_pos, 32'h12345678);
    $display("test objects done at %0t", $time);
    status_is(16'h03af);
    mode_of_op = dso_pkg::MODE_CST;
    flim_sel = 1'b1;
    soft_limit_en = 1'b0;
    prohibit_decel = 1'b1;
    backup_busy = 1'b1;
    speed_cmd = 32'sh64;
    speed_limit_value = 32'h32;
    max_profile_vel = 32'h1e;
    speed_limit_sel = 1'b1;
    status_is(16'h0015);
    chk(speed_clamped, 32'h1e);
    {mode_of_op, flim_sel, soft_limit_en, target_ignored} = {dso_pkg::MODE_HM, 3'b011};
    {backup_busy, speed_limit_sel, cmd_incr_pre, cmd_incr_post} = {2'b00, 32'sh0, 32'sh9};
    {pos_actual, vel_actual, speed_cmd_pre_acc} = {-32'shc8, -32'sh5, -32'sh6};
    {pos_err_cmd, prox_range} = {-32'sh5, 32'h8};
    status_is(16'h03c8);
    chk(speed_clamped, 32'h64);
    gen_dist_done = 1'b1;
    homing_done = 1'b0;
    status_is(16'h038a);
    servo_cmd_accept = 1'b1;
    step();
    servo_cmd_accept = 1'b0;
    status_is(16'h018a);
    servo_state_reached = 1'b1;
    step();
    servo_state_reached = 1'b0;
    status_is(16'h038a);
    $display("test status done at %0t", $time);
    wr(1'b1, dso_pkg::IDX_COMMIT, dso_pkg::KEY_COMMIT, dso_pkg::ABORT_CA);
    wr(1'b0, dso_pkg::IDX_COMMIT, 32'h666e6f62, dso_pkg::ABORT_VALUE);
    undervolt_err = 1'b1;
    wr(1'b0, dso_pkg::IDX_COMMIT, dso_pkg::KEY_COMMIT, dso_pkg::ABORT_STATE);
    undervolt_err = 1'b0;
    wr(1'b0, dso_pkg::IDX_COMMIT, dso_pkg::KEY_COMMIT, 32'h0);
    chk(servo_force_off, 1'b1);
    wr(1'b0, dso_pkg::IDX_FAULT_RST, dso_pkg::KEY_FAULT_RST, dso_pkg::ABORT_STATE);
    wait_high(1'b1, 3000);
    step();
    chk(fault, 1'b1);
    rd_is(dso_pkg::IDX_SUB_ERR, 32'hf727);
    $display("test commit done at %0t", $time);
    wr(1'b1, dso_pkg::IDX_FAULT_RST, dso_pkg::KEY_FAULT_RST, dso_pkg::ABORT_CA);
    wr(1'b0, dso_pkg::IDX_FAULT_RST, 32'h0, dso_pkg::ABORT_VALUE);
    undervolt_err = 1'b1;
    wr(1'b0, dso_pkg::IDX_FAULT_RST, dso_pkg::KEY_FAULT_RST, 32'h0);
    undervolt_err = 1'b0;
    repeat (505) step();
    chk(fault, 1'b0);
    rd_is(dso_pkg::IDX_SUB_ERR, 32'h0);
    {err_main, err_sub, err_set} = {8'h11, 4'h0, 1'b1};
    step();
    err_set = 1'b0;
    step();
    rd_is(dso_pkg::IDX_SUB_ERR, 32'hf011);
    servo_on = 1'b0;
    status_is(16'h0382);
    $display("test reset done at %0t", $time);
    report_and_stop();
  end
endmodule : tb_top
